// ### common/sfrb_regs.vh
// Register offsets, field positions, reset values and timing counts of the SFR bank
`ifndef SFRB_REGS_VH
`define SFRB_REGS_VH

`define SFRB_SPACE_BIT 7
`define SFRB_ADDR_PORT0 8'h80
`define SFRB_ADDR_STACK 8'h81
`define SFRB_ADDR_PTR0_LO 8'h82
`define SFRB_ADDR_PTR0_HI 8'h83
`define SFRB_ADDR_PTR1_LO 8'h84
`define SFRB_ADDR_PTR1_HI 8'h85
`define SFRB_ADDR_PTR_SEL 8'h86
`define SFRB_ADDR_PWR 8'h87
`define SFRB_ADDR_TCTL 8'h88
`define SFRB_ADDR_TIMER_MODES 8'h89
`define SFRB_ADDR_T0_LO 8'h8a
`define SFRB_ADDR_T1_LO 8'h8b
`define SFRB_ADDR_T0_HI 8'h8c
`define SFRB_ADDR_T1_HI 8'h8d

// Power control fields
`define SFRB_PWR_BAUD 7
`define SFRB_PWR_FEEN 6
`define SFRB_PWR_UFB 3
`define SFRB_PWR_UFA 2
`define SFRB_PWR_PD 1
`define SFRB_PWR_IDLE 0
`define SFRB_PWR_UNIMP 8'h30

// Timer control fields
`define SFRB_TC_TF1 7
`define SFRB_TC_TR1 6
`define SFRB_TC_TF0 5
`define SFRB_TC_TR0 4
`define SFRB_TC_IE1 3
`define SFRB_TC_IT1 2
`define SFRB_TC_IE0 1
`define SFRB_TC_IT0 0

// Timer mode fields, per timer nibble
`define SFRB_TM_GATE 3
`define SFRB_TM_CT 2

// Reset values
`define SFRB_RST_PORT0 8'hff
`define SFRB_RST_STACK 8'h07
`define SFRB_RST_BYTE 8'h00
`define SFRB_RST_UNIMP 8'hff

// Timer clock dividers
`define SFRB_DIV_FAST 4
`define SFRB_DIV_SLOW 12
`define SFRB_PRE_LAST 4'hb

`endif

// ### rtl/sfrb_core.v
// SFR bank of the core: port 0, stack top, dual pointers, power control and timers 0/1
`timescale 1ns/1ps
//
// Behaviour
// - Decode 80h-FFh, direct addressing only.
// - Bit operations only at addresses ending 0/8.
// - Unimplemented locations and power-control bits read one.
// - Select bit chooses active pointer pair.
// - Upper pointer-select bits read zero.
// - Unselected pointer pair stays plain storage.
// - Eight-bit stack top register.
// - Port 0 open-drain, or external address/data.
// - Baud doubler doubles serial modes 1-3.
// - Frame-error enable repurposes serial control bit 7.
// - Two user flags, no hardware effect.
// - Power down stops all clocks.
// - Idle stops CPU, peripherals keep running.
// - Overflow flags: hardware set, vector clears.
// - Timer counts only while run bit set.
// - External flag: edge clears on vector, level tracks.
// - Type bit: one falling edge, zero low level.
// - Gate bit needs pin high and run.
// - Count source: internal clock or pin falls.
// - Modes: 13-bit, 16-bit, 8-bit auto-reload.
// - Mode 3 splits timer 0, stops timer 1.
// - Timer rate one per 4 or 12 clocks.
`include "sfrb_regs.vh"

module sfrb_core (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_direct,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire sfr_bit_op,
  input wire [2:0] sfr_bit_pos,
  input wire sfr_bit_val,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  output reg sfr_rbit_r,
  output reg sfr_rvalid_r,
  input wire ptr_upd,
  input wire [15:0] ptr_val,
  output reg [15:0] active_pointer_r,
  input wire [7:0] p0_in,
  output reg [7:0] p0_out_r,
  output reg [7:0] p0_oe_n_r,
  input wire ext_bus_en,
  input wire ext_bus_drive,
  input wire [7:0] ext_bus_dout,
  input wire wake_in,
  output reg cpu_stall_r,
  output reg periph_stall_r,
  output reg baud_doubler_r,
  output reg frame_error_enable_r,
  input wire t0_fast,
  input wire t1_fast,
  input wire t0_pin,
  input wire t1_pin,
  input wire ext0_irq_pin_n,
  input wire ext1_irq_pin_n,
  input wire t0_ack,
  input wire t1_ack,
  input wire ex0_ack,
  input wire ex1_ack,
  output reg overflow_flag_t0_r,
  output reg overflow_flag_t1_r,
  output reg ext0_pending_r,
  output reg ext1_pending_r
);

  // One count step: {overflow, high, low}
  function [16:0] sfrb_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [8:0] s;
    begin
      s = 9'h000;
      sfrb_step = {1'b0, hi, lo};
      case (mode)
        2'b00: begin
          if (lo[4:0] == 5'h1f) begin
            s = {1'b0, hi} + 9'h001;
            sfrb_step = {s[8], s[7:0], lo[7:5], 5'h00};
          end else begin
            sfrb_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        2'b01: begin
          sfrb_step = {1'b0, hi, lo} + 17'h00001;
        end
        2'b10: begin
          if (lo == 8'hff) begin
            sfrb_step = {1'b1, hi, hi};
          end else begin
            sfrb_step = {1'b0, hi, lo + 8'h01};
          end
        end
        2'b11: begin
          sfrb_step = {(lo == 8'hff), hi, lo + 8'h01};
        end
        default: begin
          sfrb_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // Byte seen by a write: whole byte or one replaced bit
  function [7:0] sfrb_merge;
    input [7:0] cur;
    input [7:0] wd;
    input bop;
    input [2:0] pos;
    input bv;
    begin
      sfrb_merge = wd;
      if (bop) begin
        sfrb_merge = cur;
        sfrb_merge[pos] = bv;
      end
    end
  endfunction

  reg [7:0] port0_io_r;
  reg [7:0] stack_top_r;
  reg [7:0] pointer0_low_r;
  reg [7:0] pointer0_high_r;
  reg [7:0] pointer1_low_r;
  reg [7:0] pointer1_high_r;
  reg pointer_select_bit_r;
  reg [7:0] power_control_r;
  reg [7:0] timer_control_r;
  reg [7:0] timer_modes_r;
  reg [7:0] timer0_low_r;
  reg [7:0] timer1_low_r;
  reg [7:0] timer0_high_r;
  reg [7:0] timer1_high_r;
  reg [3:0] pre_cnt_r;
  reg t0_pin_prev_r;
  reg t1_pin_prev_r;
  reg ext0_prev_r;
  reg ext1_prev_r;

  reg [7:0] cur_byte;
  reg [7:0] rd_byte;
  reg [7:0] pwr_nxt;
  reg [7:0] tctl_nxt;
  reg [7:0] tl0_nxt;
  reg [7:0] th0_nxt;
  reg [7:0] tl1_nxt;
  reg [7:0] th1_nxt;
  reg [16:0] st0;
  reg [16:0] st1;
  reg [8:0] sth;
  reg ovf0;
  reg ovf1;

  wire in_space = sfr_direct & sfr_addr[`SFRB_SPACE_BIT];
  wire bit_ok = (sfr_addr[2:0] == 3'h0);
  wire wr_ok = in_space & sfr_wr & (~sfr_bit_op | bit_ok);
  wire rd_ok = in_space & sfr_rd & (~sfr_bit_op | bit_ok);
  wire [7:0] wbyte = sfrb_merge(cur_byte, sfr_wdata, sfr_bit_op, sfr_bit_pos, sfr_bit_val);

  wire we_port0 = wr_ok & (sfr_addr == `SFRB_ADDR_PORT0);
  wire we_stack = wr_ok & (sfr_addr == `SFRB_ADDR_STACK);
  wire we_p0lo = wr_ok & (sfr_addr == `SFRB_ADDR_PTR0_LO);
  wire we_p0hi = wr_ok & (sfr_addr == `SFRB_ADDR_PTR0_HI);
  wire we_p1lo = wr_ok & (sfr_addr == `SFRB_ADDR_PTR1_LO);
  wire we_p1hi = wr_ok & (sfr_addr == `SFRB_ADDR_PTR1_HI);
  wire we_psel = wr_ok & (sfr_addr == `SFRB_ADDR_PTR_SEL);
  wire we_pwr = wr_ok & (sfr_addr == `SFRB_ADDR_PWR);
  wire we_tctl = wr_ok & (sfr_addr == `SFRB_ADDR_TCTL);
  wire we_timer_modes = wr_ok & (sfr_addr == `SFRB_ADDR_TIMER_MODES);
  wire we_tl0 = wr_ok & (sfr_addr == `SFRB_ADDR_T0_LO);
  wire we_tl1 = wr_ok & (sfr_addr == `SFRB_ADDR_T1_LO);
  wire we_th0 = wr_ok & (sfr_addr == `SFRB_ADDR_T0_HI);
  wire we_th1 = wr_ok & (sfr_addr == `SFRB_ADDR_T1_HI);

  // Divider: fast tick every 4 clocks, slow every 12; frozen in power down
  wire pd_on = power_control_r[`SFRB_PWR_PD];
  wire tick_slow = ~pd_on & (pre_cnt_r == 4'h0);
  wire tick_fast = ~pd_on & (pre_cnt_r[1:0] == 2'b00);
  wire pre0 = t0_fast ? tick_fast : tick_slow;
  wire pre1 = t1_fast ? tick_fast : tick_slow;

  wire [1:0] mode0 = timer_modes_r[1:0];
  wire [1:0] mode1 = timer_modes_r[5:4];
  wire t0_split = (mode0 == 2'b11);
  wire tr0 = timer_control_r[`SFRB_TC_TR0];
  wire tr1 = timer_control_r[`SFRB_TC_TR1];
  wire run0 = tr0 & (~timer_modes_r[`SFRB_TM_GATE] | ext0_irq_pin_n);
  wire run1 = tr1 & (~timer_modes_r[4 + `SFRB_TM_GATE] | ext1_irq_pin_n);
  wire fall_t0 = ~pd_on & t0_pin_prev_r & ~t0_pin;
  wire fall_t1 = ~pd_on & t1_pin_prev_r & ~t1_pin;
  wire src0 = timer_modes_r[`SFRB_TM_CT] ? fall_t0 : pre0;
  wire src1 = timer_modes_r[4 + `SFRB_TM_CT] ? fall_t1 : pre1;
  wire tick0 = run0 & src0;
  wire tick1 = run1 & src1 & (mode1 != 2'b11);
  wire tick0h = t0_split & tr1 & pre0;
  wire fall_x0 = ext0_prev_r & ~ext0_irq_pin_n;
  wire fall_x1 = ext1_prev_r & ~ext1_irq_pin_n;

  // Current byte for bit merges; port 0 merges on its latch
  always @* begin
    case (sfr_addr)
      `SFRB_ADDR_PORT0: cur_byte = port0_io_r;
      `SFRB_ADDR_TCTL: cur_byte = timer_control_r;
      default: cur_byte = `SFRB_RST_UNIMP;
    endcase
  end

  always @* begin
    case (sfr_addr)
      `SFRB_ADDR_PORT0: rd_byte = p0_in;
      `SFRB_ADDR_STACK: rd_byte = stack_top_r;
      `SFRB_ADDR_PTR0_LO: rd_byte = pointer0_low_r;
      `SFRB_ADDR_PTR0_HI: rd_byte = pointer0_high_r;
      `SFRB_ADDR_PTR1_LO: rd_byte = pointer1_low_r;
      `SFRB_ADDR_PTR1_HI: rd_byte = pointer1_high_r;
      `SFRB_ADDR_PTR_SEL: rd_byte = {7'h00, pointer_select_bit_r};
      `SFRB_ADDR_PWR: rd_byte = power_control_r | `SFRB_PWR_UNIMP;
      `SFRB_ADDR_TCTL: rd_byte = timer_control_r;
      `SFRB_ADDR_TIMER_MODES: rd_byte = timer_modes_r;
      `SFRB_ADDR_T0_LO: rd_byte = timer0_low_r;
      `SFRB_ADDR_T1_LO: rd_byte = timer1_low_r;
      `SFRB_ADDR_T0_HI: rd_byte = timer0_high_r;
      `SFRB_ADDR_T1_HI: rd_byte = timer1_high_r;
      default: rd_byte = `SFRB_RST_UNIMP;
    endcase
  end

  // Timer datapath; a software write to a byte wins over the count
  always @* begin
    st0 = sfrb_step(mode0, timer0_low_r, timer0_high_r);
    st1 = sfrb_step(mode1, timer1_low_r, timer1_high_r);
    sth = {1'b0, timer0_high_r} + 9'h001;
    tl0_nxt = timer0_low_r;
    th0_nxt = timer0_high_r;
    tl1_nxt = timer1_low_r;
    th1_nxt = timer1_high_r;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    if (tick0) begin
      tl0_nxt = st0[7:0];
      ovf0 = st0[16];
      if (!t0_split) begin
        th0_nxt = st0[15:8];
      end
    end
    if (tick0h) begin
      th0_nxt = sth[7:0];
      ovf1 = sth[8];
    end
    if (tick1) begin
      tl1_nxt = st1[7:0];
      th1_nxt = st1[15:8];
      if (!t0_split) begin
        ovf1 = st1[16];
      end
    end
    if (we_tl0) tl0_nxt = wbyte;
    if (we_th0) th0_nxt = wbyte;
    if (we_tl1) tl1_nxt = wbyte;
    if (we_th1) th1_nxt = wbyte;
  end

  // Timer control: hardware set wins over software or vector clear
  always @* begin
    tctl_nxt = we_tctl ? wbyte : timer_control_r;
    tctl_nxt[`SFRB_TC_TF0] = ovf0 | (we_tctl ? wbyte[`SFRB_TC_TF0] : (timer_control_r[`SFRB_TC_TF0] & ~t0_ack));
    tctl_nxt[`SFRB_TC_TF1] = ovf1 | (we_tctl ? wbyte[`SFRB_TC_TF1] : (timer_control_r[`SFRB_TC_TF1] & ~t1_ack));
    if (tctl_nxt[`SFRB_TC_IT0]) begin
      tctl_nxt[`SFRB_TC_IE0] = fall_x0 | (we_tctl ? wbyte[`SFRB_TC_IE0] :
                               (timer_control_r[`SFRB_TC_IE0] & ~ex0_ack));
    end else begin
      tctl_nxt[`SFRB_TC_IE0] = ~ext0_irq_pin_n;
    end
    if (tctl_nxt[`SFRB_TC_IT1]) begin
      tctl_nxt[`SFRB_TC_IE1] = fall_x1 | (we_tctl ? wbyte[`SFRB_TC_IE1] :
                               (timer_control_r[`SFRB_TC_IE1] & ~ex1_ack));
    end else begin
      tctl_nxt[`SFRB_TC_IE1] = ~ext1_irq_pin_n;
    end
  end

  // Power control: wake-up ends idle and power down
  always @* begin
    pwr_nxt = we_pwr ? (wbyte & ~`SFRB_PWR_UNIMP) : power_control_r;
    if (wake_in) begin
      pwr_nxt[`SFRB_PWR_PD] = 1'b0;
      pwr_nxt[`SFRB_PWR_IDLE] = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      port0_io_r <= `SFRB_RST_PORT0;
      stack_top_r <= `SFRB_RST_STACK;
      pointer0_low_r <= `SFRB_RST_BYTE;
      pointer0_high_r <= `SFRB_RST_BYTE;
      pointer1_low_r <= `SFRB_RST_BYTE;
      pointer1_high_r <= `SFRB_RST_BYTE;
      pointer_select_bit_r <= 1'b0;
      power_control_r <= `SFRB_RST_BYTE;
      timer_control_r <= `SFRB_RST_BYTE;
      timer_modes_r <= `SFRB_RST_BYTE;
      timer0_low_r <= `SFRB_RST_BYTE;
      timer1_low_r <= `SFRB_RST_BYTE;
      timer0_high_r <= `SFRB_RST_BYTE;
      timer1_high_r <= `SFRB_RST_BYTE;
      pre_cnt_r <= 4'h0;
      t0_pin_prev_r <= 1'b0;
      t1_pin_prev_r <= 1'b0;
      ext0_prev_r <= 1'b0;
      ext1_prev_r <= 1'b0;
    end else begin
      if (we_port0) port0_io_r <= wbyte;
      if (we_stack) stack_top_r <= wbyte;
      // Pointer instructions act on the selected pair only
      if (ptr_upd && !pointer_select_bit_r) begin
        pointer0_low_r <= ptr_val[7:0];
        pointer0_high_r <= ptr_val[15:8];
      end
      if (ptr_upd && pointer_select_bit_r) begin
        pointer1_low_r <= ptr_val[7:0];
        pointer1_high_r <= ptr_val[15:8];
      end
      if (we_p0lo) pointer0_low_r <= wbyte;
      if (we_p0hi) pointer0_high_r <= wbyte;
      if (we_p1lo) pointer1_low_r <= wbyte;
      if (we_p1hi) pointer1_high_r <= wbyte;
      if (we_psel) pointer_select_bit_r <= wbyte[0];
      power_control_r <= pwr_nxt;
      timer_control_r <= tctl_nxt;
      if (we_timer_modes) timer_modes_r <= wbyte;
      timer0_low_r <= tl0_nxt;
      timer0_high_r <= th0_nxt;
      timer1_low_r <= tl1_nxt;
      timer1_high_r <= th1_nxt;
      if (!pd_on) pre_cnt_r <= (pre_cnt_r == `SFRB_PRE_LAST) ? 4'h0 : pre_cnt_r + 4'h1;
      t0_pin_prev_r <= t0_pin;
      t1_pin_prev_r <= t1_pin;
      ext0_prev_r <= ext0_irq_pin_n;
      ext1_prev_r <= ext1_irq_pin_n;
    end
  end
  // Other addresses fall through every decode above

  // Outputs, all from flops
  always @(posedge core_clk) begin
    if (!resetn) begin
      sfr_rdata_r <= `SFRB_RST_UNIMP;
      sfr_rbit_r <= 1'b0;
      sfr_rvalid_r <= 1'b0;
      active_pointer_r <= {`SFRB_RST_BYTE, `SFRB_RST_BYTE};
      p0_out_r <= 8'h00;
      p0_oe_n_r <= 8'hff;
      cpu_stall_r <= 1'b0;
      periph_stall_r <= 1'b0;
      baud_doubler_r <= 1'b0;
      frame_error_enable_r <= 1'b0;
      overflow_flag_t0_r <= 1'b0;
      overflow_flag_t1_r <= 1'b0;
      ext0_pending_r <= 1'b0;
      ext1_pending_r <= 1'b0;
    end else begin
      sfr_rvalid_r <= rd_ok;
      if (rd_ok) begin
        sfr_rdata_r <= rd_byte;
        sfr_rbit_r <= rd_byte[sfr_bit_pos];
      end
      active_pointer_r <= (we_psel ? wbyte[0] : pointer_select_bit_r) ?
                          {(we_p1hi ? wbyte : (ptr_upd && pointer_select_bit_r) ? ptr_val[15:8] : pointer1_high_r),
                           (we_p1lo ? wbyte : (ptr_upd && pointer_select_bit_r) ? ptr_val[7:0] : pointer1_low_r)} :
                          {(we_p0hi ? wbyte : (ptr_upd && !pointer_select_bit_r) ? ptr_val[15:8] : pointer0_high_r),
                           (we_p0lo ? wbyte : (ptr_upd && !pointer_select_bit_r) ? ptr_val[7:0] : pointer0_low_r)};
      if (ext_bus_en) begin
        p0_out_r <= ext_bus_dout;
        p0_oe_n_r <= ext_bus_drive ? 8'h00 : 8'hff;
      end else begin
        p0_out_r <= 8'h00;
        p0_oe_n_r <= we_port0 ? wbyte : port0_io_r;
      end
      cpu_stall_r <= pwr_nxt[`SFRB_PWR_PD] | pwr_nxt[`SFRB_PWR_IDLE];
      periph_stall_r <= pwr_nxt[`SFRB_PWR_PD];
      baud_doubler_r <= pwr_nxt[`SFRB_PWR_BAUD];
      frame_error_enable_r <= pwr_nxt[`SFRB_PWR_FEEN];
      overflow_flag_t0_r <= tctl_nxt[`SFRB_TC_TF0];
      overflow_flag_t1_r <= tctl_nxt[`SFRB_TC_TF1];
      ext0_pending_r <= tctl_nxt[`SFRB_TC_IE0];
      ext1_pending_r <= tctl_nxt[`SFRB_TC_IE1];
    end
  end

endmodule // sfrb_core

// ### verif/sfrb_cpu_model.sv
// CPU core model issuing direct-addressed SFR accesses
`timescale 1ns/1ps
module sfrb_cpu_model (
  input wire core_clk,
  input wire [7:0] sfr_rdata_r,
  input wire sfr_rvalid_r,
  output reg [7:0] sfr_addr,
  output reg sfr_direct,
  output reg sfr_wr,
  output reg sfr_rd,
  output reg sfr_bit_op,
  output reg [2:0] sfr_bit_pos,
  output reg sfr_bit_val,
  output reg [7:0] sfr_wdata
);
  initial begin
    {sfr_addr, sfr_direct, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_pos, sfr_bit_val, sfr_wdata} = 24'h0;
  end
  // Request held over one sampling edge; idle address and data show the inverse of the last values
  task acc(input [7:0] a, input dir, input w, input r, input b, input [2:0] p, input [7:0] d, output v,
           output [7:0] q);
    begin
      @(posedge core_clk);
      #1;
      {sfr_addr, sfr_direct, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_pos, sfr_bit_val, sfr_wdata} = {a, dir, w, r, b, p, d[0], d};
      @(posedge core_clk);
      #1;
      v = sfr_rvalid_r;
      q = sfr_rdata_r;
      {sfr_addr, sfr_direct, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_wdata} = {~a, 5'h0, ~d};
    end
  endtask
endmodule // sfrb_cpu_model

// ### verif/sfrb_core_props.sv
// Concurrent checks on the SFR bank ports
`timescale 1ns/1ps
module sfrb_core_props (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_direct,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire sfr_bit_op,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_r,
  input wire sfr_rvalid_r,
  input wire [7:0] p0_oe_n_r,
  input wire ext_bus_en,
  input wire ext_bus_drive,
  input wire wake_in,
  input wire cpu_stall_r,
  input wire periph_stall_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire take = sfr_direct && sfr_addr[7] && (!sfr_bit_op || sfr_addr[2:0] == 3'h0);
  sequence s_rd; sfr_rd && take; endsequence
  sequence s_pwr_wr; sfr_wr && take && sfr_addr == 8'h87 && !sfr_bit_op && !wake_in; endsequence
  property p_rvalid; s_rd |=> sfr_rvalid_r; endproperty
  a_rvalid: assert property (p_rvalid) else $error("taken read gave no valid");
  property p_refused; sfr_rd && !take |=> !sfr_rvalid_r; endproperty
  a_refused: assert property (p_refused) else $error("refused read gave valid");
  property p_unimp; s_rd ##0 sfr_addr > 8'h8d |=> sfr_rdata_r == 8'hff; endproperty
  a_unimp: assert property (p_unimp) else $error("unmapped read not all ones");
  property p_psel; s_rd ##0 sfr_addr == 8'h86 |=> sfr_rdata_r[7:1] == 7'h0; endproperty
  a_psel: assert property (p_psel) else $error("select upper bits not zero");
  property p_pwr_rd; s_rd ##0 sfr_addr == 8'h87 |=> sfr_rdata_r[5:4] == 2'b11; endproperty
  a_pwr_rd: assert property (p_pwr_rd) else $error("power control spare bits not one");
  property p_pd; s_pwr_wr ##0 sfr_wdata[1] |-> ##[1:2] (cpu_stall_r && periph_stall_r); endproperty
  a_pd: assert property (p_pd) else $error("power down did not stop clocks");
  property p_idle; s_pwr_wr ##0 sfr_wdata[1:0] == 2'b01 |-> ##[1:2] (cpu_stall_r && !periph_stall_r); endproperty
  a_idle: assert property (p_idle) else $error("idle stall wrong");
  property p_extbus; ext_bus_en && ext_bus_drive |-> ##[1:2] p0_oe_n_r == 8'h00; endproperty
  a_extbus: assert property (p_extbus) else $error("port 0 not driven for external bus");
endmodule // sfrb_core_props
bind sfrb_core sfrb_core_props u_props (.core_clk, .resetn, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd, .sfr_bit_op,
  .sfr_wdata, .sfr_rdata_r, .sfr_rvalid_r, .p0_oe_n_r, .ext_bus_en, .ext_bus_drive, .wake_in, .cpu_stall_r,
  .periph_stall_r);

// ### verif/testbench.sv
// Self-checking bench for the SFR bank and timers
`timescale 1ns/1ps
module testbench;
  reg core_clk, resetn, ptr_upd, wake_in, t0_fast, t0_pin, ext0_irq_pin_n, t0_ack, ex0_ack, ext_bus_en, ext_bus_drive;
  reg t1_ack, ext1_irq_pin_n;
  reg [15:0] ptr_val;
  reg [7:0] p0_in, ext_bus_dout, q, d, a;
  reg v;
  integer seed, failures, n_compared, i, n;
  wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, p0_out_r, p0_oe_n_r;
  wire [2:0] sfr_bit_pos;
  wire [15:0] active_pointer_r;
  wire sfr_direct, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_rbit_r, sfr_rvalid_r, cpu_stall_r, periph_stall_r;
  wire baud_doubler_r, frame_error_enable_r, overflow_flag_t0_r, overflow_flag_t1_r, ext0_pending_r, ext1_pending_r;
  sfrb_cpu_model cpu (.core_clk, .sfr_rdata_r, .sfr_rvalid_r, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd, .sfr_bit_op,
    .sfr_bit_pos, .sfr_bit_val, .sfr_wdata);
  sfrb_core DUT (.core_clk, .resetn, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd, .sfr_bit_op, .sfr_bit_pos, .sfr_bit_val,
    .sfr_wdata, .sfr_rdata_r, .sfr_rbit_r, .sfr_rvalid_r, .ptr_upd, .ptr_val, .active_pointer_r, .p0_in, .p0_out_r,
    .p0_oe_n_r, .ext_bus_en, .ext_bus_drive, .ext_bus_dout, .wake_in, .cpu_stall_r, .periph_stall_r, .baud_doubler_r,
    .frame_error_enable_r, .t0_fast, .t1_fast(1'b0), .t0_pin, .t1_pin(1'b1), .ext0_irq_pin_n, .ext1_irq_pin_n,
    .t0_ack, .t1_ack, .ex0_ack, .ex1_ack(1'b0), .overflow_flag_t0_r, .overflow_flag_t1_r, .ext0_pending_r,
    .ext1_pending_r);
  function [7:0] rst_val(input [7:0] ad);
    rst_val = (ad == 8'h81) ? 8'h07 : (ad == 8'h87) ? 8'h30 : (ad > 8'h8d) ? 8'hff : 8'h00;
  endfunction
  task chk(input [8*8-1:0] nm, input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [7:0] ad, input [7:0] dd);
    cpu.acc(ad, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, dd, v, q);
  endtask
  task rdc(input [7:0] ad, input [7:0] e);
    begin
      cpu.acc(ad, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00, v, q);
      chk("rvalid", v, 1'b1);
      chk("rdata", q, e);
    end
  endtask
  task results;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #(25 * 8000);
    failures = failures + 1;
    results;
  end
  initial begin
    seed = 88;
    failures = 0;
    n_compared = 0;
    resetn = 0;
    {ptr_upd, wake_in, t0_pin, t0_ack, t1_ack, ex0_ack, ext_bus_en, ext_bus_drive} = 8'h00;
    t0_fast = 1;
    {ext0_irq_pin_n, ext1_irq_pin_n} = 2'b11;
    ptr_val = 16'h0000;
    p0_in = $random(seed);
    ext_bus_dout = 8'h00;
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1;
    for (a = 8'h81; a != 8'h90; a = a + 1) rdc(a, rst_val(a));
    rdc(8'h80, p0_in);
    a = 8'h8e | $random(seed);
    wr(a, 8'h00);
    rdc(a, 8'hff);
    cpu.acc(8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00, v, q);
    chk("indirect", v, 1'b0);
    cpu.acc(8'h7f, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00, v, q);
    chk("low", v, 1'b0);
    cpu.acc(8'h81, 1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 8'h00, v, q);
    chk("bitref", v, 1'b0);
    cpu.acc(8'h88, 1'b1, 1'b1, 1'b0, 1'b1, 3'h2, 8'h01, v, q);
    rdc(8'h88, 8'h04);
    cpu.acc(8'h88, 1'b1, 1'b0, 1'b1, 1'b1, 3'h2, 8'h00, v, q);
    chk("rbitv", v, 1'b1);
    chk("rbit", sfr_rbit_r, 1'b1);
    wr(8'h88, 8'h00);
    for (i = 0; i < 16; i = i + 1) begin
      a = i[0] ? 8'h8a + {$random(seed)} % 4 : 8'h81 + {$random(seed)} % 5;
      d = $random(seed);
      wr(a, d);
      rdc(a, d);
    end
    wr(8'h82, 8'h11);
    wr(8'h83, 8'h22);
    wr(8'h84, 8'h33);
    wr(8'h85, 8'h44);
    wr(8'h86, 8'hff);
    rdc(8'h86, 8'h01);
    chk("ptr", active_pointer_r, 16'h4433);
    ptr_val = $random(seed);
    ptr_upd = 1;
    cyc(1);
    ptr_upd = 0;
    chk("ptr", active_pointer_r, ptr_val);
    rdc(8'h84, ptr_val[7:0]);
    rdc(8'h82, 8'h11);
    wr(8'h86, 8'h00);
    chk("ptr", active_pointer_r, 16'h2211);
    wr(8'h87, 8'hcc);
    rdc(8'h87, 8'hfc);
    chk("baud", baud_doubler_r, 1'b1);
    chk("feen", frame_error_enable_r, 1'b1);
    wr(8'h87, 8'h01);
    cyc(1);
    chk("stall", {cpu_stall_r, periph_stall_r}, 2'b10);
    wake_in = 1;
    cyc(1);
    wake_in = 0;
    cyc(1);
    chk("stall", cpu_stall_r, 1'b0);
    wr(8'h87, 8'h02);
    cyc(1);
    chk("stall", {cpu_stall_r, periph_stall_r}, 2'b11);
    wake_in = 1;
    cyc(1);
    wake_in = 0;
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h89, i[7:0]);
      wr(8'h8a, i == 0 ? 8'h1e : 8'hfe);
      wr(8'h8c, i == 2 ? 8'hb0 : 8'hff);
      chk("ovf0", overflow_flag_t0_r, 1'b0);
      wr(8'h88, 8'h10);
      for (n = 0; n < 40 && overflow_flag_t0_r !== 1'b1; n = n + 1) cyc(1);
      chk("ovf0", overflow_flag_t0_r, 1'b1);
      rdc(8'h8c, i == 2 ? 8'hb0 : 8'h00);
      t0_ack = 1;
      cyc(1);
      t0_ack = 0;
      chk("ovf0", overflow_flag_t0_r, 1'b0);
      wr(8'h88, 8'h00);
    end
    for (i = 0; i < 2; i = i + 1) begin
      t0_fast = i[0];
      wr(8'h89, 8'h02);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'hff);
      wr(8'h88, 8'h10);
      for (n = 0; n < 40 && overflow_flag_t0_r !== 1'b1; n = n + 1) cyc(1);
      t0_ack = 1;
      cyc(1);
      t0_ack = 0;
      for (n = 1; n < 40 && overflow_flag_t0_r !== 1'b1; n = n + 1) cyc(1);
      chk("rate", n[15:0], i[0] ? 16'h0004 : 16'h000c);
      wr(8'h88, 8'h00);
    end
    wr(8'h89, 8'h03);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h40);
    for (n = 0; n < 40 && overflow_flag_t1_r !== 1'b1; n = n + 1) cyc(1);
    chk("ovf1", {overflow_flag_t1_r, overflow_flag_t0_r}, 2'b10);
    t1_ack = 1;
    cyc(1);
    t1_ack = 0;
    chk("ovf1", overflow_flag_t1_r, 1'b0);
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    ext0_irq_pin_n = 0;
    wr(8'h88, 8'h10);
    cyc(20);
    chk("gate", overflow_flag_t0_r, 1'b0);
    ext0_irq_pin_n = 1;
    cyc(12);
    chk("gate", overflow_flag_t0_r, 1'b1);
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h10);
    cyc(20);
    chk("count", overflow_flag_t0_r, 1'b0);
    t0_pin = 1;
    cyc(3);
    t0_pin = 0;
    cyc(4);
    chk("count", overflow_flag_t0_r, 1'b1);
    wr(8'h88, 8'h00);
    {ext0_irq_pin_n, ext1_irq_pin_n} = 2'b00;
    cyc(2);
    chk("lvl", {ext1_pending_r, ext0_pending_r}, 2'b11);
    {ext0_irq_pin_n, ext1_irq_pin_n} = 2'b11;
    cyc(2);
    chk("lvl", {ext1_pending_r, ext0_pending_r}, 2'b00);
    wr(8'h88, 8'h01);
    ext0_irq_pin_n = 0;
    cyc(2);
    ext0_irq_pin_n = 1;
    cyc(2);
    chk("edge", ext0_pending_r, 1'b1);
    ex0_ack = 1;
    cyc(1);
    ex0_ack = 0;
    chk("edge", ext0_pending_r, 1'b0);
    wr(8'h80, 8'h0f);
    cyc(1);
    chk("oe_n", p0_oe_n_r, 8'h0f);
    ext_bus_dout = $random(seed);
    {ext_bus_en, ext_bus_drive} = 2'b11;
    cyc(2);
    chk("p0out", {p0_oe_n_r, p0_out_r}, {8'h00, ext_bus_dout});
    ext_bus_drive = 0;
    cyc(2);
    chk("oe_n", p0_oe_n_r, 8'hff);
    ext_bus_en = 0;
    cyc(2);
    chk("p0back", {p0_oe_n_r, p0_out_r}, {8'h0f, 8'h00});
    results;
  end
endmodule // testbench
